/* awf_datapath.sv */
// add and and instruction datapath with its working and file registers
// assumes a classic wishbone master on the same clock
`timescale 1ns/100ps
`default_nettype none
module awf_datapath #(
    parameter int NFILE = 128
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [7:0]  work_o,
    output logic             carry_o,
    output logic             digit_carry_flag_o,
    output logic             zero_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  work_q;
    logic [3:0]  stat_q;
    logic [6:0]  fptr_q;
    logic [7:0]  file_q [NFILE];
    logic        ack_q;
    logic [31:0] rdat_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // writes land on the edge where the master sees ack, never earlier
    wire         req      = wb_cyc_i & wb_stb_i;
    wire         wr_fire  = req & wb_we_i & ack_q;
    wire         lane0    = wb_sel_i[0];
    wire         hit_insn = wb_adr_i == awf_pkg::OFS_INSN;
    wire         hit_work = wb_adr_i == awf_pkg::OFS_WORK;
    wire         hit_stat = wb_adr_i == awf_pkg::OFS_STAT;
    wire         hit_fptr = wb_adr_i == awf_pkg::OFS_FPTR;
    wire         hit_fdat = wb_adr_i == awf_pkg::OFS_FDAT;
    // opcode needs both low lanes, so a partial write cannot execute junk
    wire         exec     = wr_fire & hit_insn & wb_sel_i[0] & wb_sel_i[1];

    // ------------------------------------------------------------------
    // opcode decode and alu
    // ------------------------------------------------------------------
    wire [5:0]   opc      = wb_dat_i[awf_pkg::OPC_HI:awf_pkg::OPC_LO];
    wire         dest_f   = wb_dat_i[awf_pkg::DEST_BIT];
    wire [6:0]   fadr     = wb_dat_i[awf_pkg::FADR_HI:0];
    wire [7:0]   lit      = wb_dat_i[7:0];
    wire [7:0]   fval     = file_q[fadr];
    wire         is_add   = opc == awf_pkg::OPC_ADD_WF;
    wire         is_andf  = opc == awf_pkg::OPC_AND_WF;
    wire         is_andl  = opc == awf_pkg::OPC_AND_LIT;
    wire         known    = is_add | is_andf | is_andl;
    wire [8:0]   sum9     = {1'b0, work_q} + {1'b0, fval};
    wire [4:0]   nib5     = {1'b0, work_q[3:0]} + {1'b0, fval[3:0]};
    wire [7:0]   andf     = work_q & fval;
    wire [7:0]   andl     = work_q & lit;
    wire [7:0]   result   = is_add ? sum9[7:0] : (is_andf ? andf : andl);
    wire         res_zero = result == 8'h00;
    // literal form has no destination bit, so it never reaches the file
    wire         to_file  = exec & (is_add | is_andf) & dest_f;
    wire         to_work  = exec & known & ~to_file;

    // ------------------------------------------------------------------
    // read mux, unmapped offsets read zero
    // ------------------------------------------------------------------
    wire [31:0]  rmux = hit_work ? {24'h000000, work_q} :
                        hit_stat ? {28'h0000000, stat_q} :
                        hit_fptr ? {25'h0, fptr_q} :
                        hit_fdat ? {24'h000000, file_q[fptr_q]} : 32'h00000000;

    // ------------------------------------------------------------------
    // bus answer: ack one cycle after the request, dropped the next
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= rmux;
        end
    end

    // ------------------------------------------------------------------
    // working register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            work_q <= awf_pkg::WORK_RST;
        end else if (to_work) begin
            work_q <= result;
        end else if (wr_fire & hit_work & lane0) begin
            work_q <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // flags: add moves all three, the and forms only zero
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= awf_pkg::STAT_RST;
        end else if (exec & known) begin
            stat_q[awf_pkg::STAT_Z] <= res_zero;
            if (is_add) begin
                stat_q[awf_pkg::STAT_C]  <= sum9[8];
                stat_q[awf_pkg::STAT_DIGIT] <= nib5[4];
            end
        end else if (exec) begin
            stat_q[awf_pkg::STAT_BADOP] <= 1'b1;                   // unknown opcode does nothing else
        end else if (wr_fire & hit_stat & lane0) begin
            stat_q <= wb_dat_i[3:0];
        end
    end

    // ------------------------------------------------------------------
    // file pointer for the data port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fptr_q <= awf_pkg::FPTR_RST;
        end else if (wr_fire & hit_fptr & lane0) begin
            fptr_q <= wb_dat_i[6:0];
        end
    end

    // ------------------------------------------------------------------
    // file registers, one write port shared by execute and bus
    // ------------------------------------------------------------------
    // the two writers are different bus writes, so they never collide
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NFILE; i++) begin
                file_q[i] <= awf_pkg::FILE_RST;
            end
        end else if (to_file) begin
            file_q[fadr] <= result;
        end else if (wr_fire & hit_fdat & lane0) begin
            file_q[fptr_q] <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------------
    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = rdat_q;
    assign work_o             = work_q;
    assign carry_o            = stat_q[awf_pkg::STAT_C];
    assign digit_carry_flag_o = stat_q[awf_pkg::STAT_DIGIT];
    assign zero_o             = stat_q[awf_pkg::STAT_Z];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_add_w;
        exec && is_add && !dest_f;
    endsequence

    a_add_to_work: assert property (s_add_w |=> work_q == $past(sum9[7:0]) && carry_o == $past(sum9[8]))
        else $error("add result or carry wrong");
    a_dest_clear: assert property (exec && known && !dest_f |=> file_q[$past(fadr)] == $past(fval))
        else $error("file changed with destination clear");
    a_dest_set: assert property (exec && !is_andl && known && dest_f
                                 |=> file_q[$past(fadr)] == $past(result) && $stable(work_q))
        else $error("file destination not written");
    a_and_lit: assert property (exec && is_andl |=> work_q == ($past(work_q) & $past(lit))
                                && $stable(carry_o) && $stable(digit_carry_flag_o))
        else $error("literal and wrong or touched carries");
    a_and_file: assert property (exec && is_andf |=> zero_o == ($past(andf) == 8'h00)
                                 && $stable(carry_o) && $stable(digit_carry_flag_o))
        else $error("file and flags wrong");
    a_lit_no_file: assert property (exec && is_andl |=> file_q[$past(fadr)] == $past(fval))
        else $error("literal and wrote the file");
    a_flag_calc: assert property (exec && is_add |=> digit_carry_flag_o == $past(nib5[4])
                                  && zero_o == ($past(sum9[7:0]) == 8'h00))
        else $error("digit carry or zero wrong");

    // ------------------------------------------------------------------
    // bus handshake checks
    // ------------------------------------------------------------------
    // an open request that is not yet answered gets its ack on the next edge
    sequence s_bus_open;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_ack_next: assert property (s_bus_open |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    // a held ack would make the master see a second transfer it never asked for
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");

    // ------------------------------------------------------------------
    // further execute checks
    // ------------------------------------------------------------------
    // an add into the file must still move all three flags
    sequence s_add_f;
        exec && is_add && dest_f;
    endsequence

    a_add_to_file: assert property (s_add_f
                                    |=> carry_o == $past(sum9[8]) && digit_carry_flag_o == $past(nib5[4])
                                    && zero_o == ($past(sum9[7:0]) == 8'h00))
        else $error("add to file flags wrong");
    a_lit_zero: assert property (exec && is_andl
                                 |=> zero_o == (($past(work_q) & $past(lit)) == 8'h00))
        else $error("literal and zero flag wrong");
    a_file_and_work: assert property (exec && is_andf && !dest_f
                                      |=> work_q == ($past(work_q) & $past(fval)))
        else $error("file and result wrong");
    // a stray opcode leaves working and flags alone, so software can retry
    a_badop_sticky: assert property (exec && !known |=> stat_q[awf_pkg::STAT_BADOP] && $stable(work_q)
                                     && $stable(carry_o) && $stable(zero_o))
        else $error("unknown opcode not flagged or state disturbed");
endmodule : awf_datapath
`default_nettype wire

/* awf_pkg.sv */
// package of constants for the add and and instruction datapath
// assumes a classic wishbone slave with 32-bit data and byte addresses
// Summary of operation
// - add adds working and file, sets carry, digit carry and zero
// - destination clear writes result to working
// - destination set writes result to file
// - literal and ands working, only zero flag
// - file and ands working and file, zero only
// - literal and always lands in working
package awf_pkg;
    // ------------------------------------------------------------------
    // register offsets, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_INSN = 8'h00; // write executes an opcode
    localparam logic [7:0] OFS_WORK = 8'h04; // working register
    localparam logic [7:0] OFS_STAT = 8'h08; // flags
    localparam logic [7:0] OFS_FPTR = 8'h0C; // file index for data port
    localparam logic [7:0] OFS_FDAT = 8'h10; // addressed file register
    // ------------------------------------------------------------------
    // opcode fields and encodings
    // ------------------------------------------------------------------
    localparam int         OPC_HI        = 13;
    localparam int         OPC_LO        = 8;
    localparam int         DEST_BIT      = 7;
    localparam int         FADR_HI       = 6;
    localparam logic [5:0] OPC_ADD_WF    = 6'h07; // 00 0111
    localparam logic [5:0] OPC_AND_WF    = 6'h05; // 00 0101
    localparam logic [5:0] OPC_AND_LIT   = 6'h39; // 11 1001
    // ------------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------------
    localparam int         STAT_C        = 0;
    localparam int         STAT_DIGIT    = 1;
    localparam int         STAT_Z        = 2;
    localparam int         STAT_BADOP    = 3;
    localparam logic [7:0] WORK_RST      = 8'h00;
    localparam logic [3:0] STAT_RST      = 4'h0;
    localparam logic [7:0] FILE_RST      = 8'h00;
    localparam logic [6:0] FPTR_RST      = 7'h00;
endpackage : awf_pkg

/* awf_datapath_tb_top.sv */
// self-checking testbench for the add and and instruction datapath
// assumes the datapath answers classic wishbone cycles on sys_clk_i, one clock domain
`timescale 1ns/100ps
`default_nettype none
module awf_datapath_tb_top;
    logic        sys_clk_i, rst_i, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, junk;
    logic [7:0]  work_o;
    logic        ack_o, carry_o, digit_o, zero_o;
    int          bad_count, check_count;
    logic [5:0]  ops [3];
    logic [5:0]  op;
    logic [7:0]  w, fv, opd;
    logic [6:0]  fa;
    logic        d, wd;
    logic [2:0]  st;
    logic [10:0] e;

    awf_datapath #(.NFILE(128)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack_o),
        .work_o(work_o), .carry_o(carry_o), .digit_carry_flag_o(digit_o), .zero_o(zero_o));

    // ------------------------------------------------------------------
    // clock, verdict and compare helpers
    // ------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one classic cycle: request held until ack is sampled, then released for a cycle
    task automatic wbx(input logic w_en, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] r);
        int n;
        @(posedge sys_clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w_en; adr <= a; wdat <= dv; sel <= 4'hF;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            results();
        end
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wbx
    // expected {result, carry, digit carry, zero}; and keeps the carries untouched
    function automatic logic [10:0] model(logic [5:0] o, logic [7:0] a, logic [7:0] b, logic c, logic h);
        logic [8:0] s;
        logic [4:0] lo;
        s = {1'b0, a} + {1'b0, b};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        if (o == awf_pkg::OPC_ADD_WF) return {s[7:0], s[8], lo[4], s[7:0] == 8'h00};
        return {a & b, c, h, (a & b) == 8'h00};
    endfunction : model

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        #(100 * 8000);
        bad_count++;
        results();
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
        bad_count = 0; check_count = 0;
        ops = '{awf_pkg::OPC_ADD_WF, awf_pkg::OPC_AND_WF, awf_pkg::OPC_AND_LIT};
        void'($urandom(33963));
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        check("reset", {21'h0, work_o, carry_o, digit_o, zero_o}, 32'h0);
        for (int i = 0; i < 80; i++) begin
            op = ops[$urandom % 3];
            w = 8'($urandom);
            fv = 8'($urandom);
            fa = 7'($urandom);
            d = 1'($urandom);
            st = 3'($urandom);
            // carry out of bit 7, carry out of bit 3, and a literal and that yields zero
            if (i == 0) begin op = awf_pkg::OPC_ADD_WF; w = 8'hFF; fv = 8'h01; d = 1'b0; end
            if (i == 1) begin op = awf_pkg::OPC_ADD_WF; w = 8'h0F; fv = 8'h01; d = 1'b1; end
            if (i == 2) begin op = awf_pkg::OPC_AND_LIT; w = 8'hA3; d = 1'b0; fa = 7'h5C; end
            wbx(1'b1, awf_pkg::OFS_FPTR, {25'h0, fa}, junk);
            wbx(1'b1, awf_pkg::OFS_FDAT, {24'h0, fv}, junk);
            wbx(1'b1, awf_pkg::OFS_WORK, {24'h0, w}, junk);
            wbx(1'b1, awf_pkg::OFS_STAT, {29'h0, st}, junk);
            wbx(1'b1, awf_pkg::OFS_INSN, {18'h0, op, d, fa}, junk);
            opd = (op == awf_pkg::OPC_AND_LIT) ? {d, fa} : fv;
            e = model(op, w, opd, st[0], st[1]);
            wd = (op != awf_pkg::OPC_AND_LIT) && d;
            #1;
            check("work", {24'h0, work_o}, {24'h0, wd ? w : e[10:3]});
            check("flags", {29'h0, carry_o, digit_o, zero_o}, {29'h0, e[2:0]});
            wbx(1'b0, awf_pkg::OFS_FDAT, 32'h0, junk);
            check("file", junk, {24'h0, wd ? e[10:3] : fv});
        end
        wbx(1'b0, 8'h40, 32'h0, junk);
        check("unmapped", junk, 32'h0);
        wbx(1'b1, awf_pkg::OFS_STAT, 32'h0, junk);
        wbx(1'b1, awf_pkg::OFS_INSN, 32'h00003F00, junk);
        wbx(1'b0, awf_pkg::OFS_STAT, 32'h0, junk);
        check("badop", junk, 32'h8);
        results();
    end
endmodule : awf_datapath_tb_top
`default_nettype wire
